// [design/lcvo_pkg.sv]
// constants and types shared by the line camera video output block
`default_nettype none
package lcvo_pkg;
  localparam int CLK_HZ       = 20_000_000;
  localparam int BAUD_DEFAULT = 9600;
  localparam int BAUD_FAST    = 230_400;
  localparam int DIV_W        = 12;
  localparam logic [DIV_W-1:0] DIV_DEFAULT =
    DIV_W'((CLK_HZ + BAUD_DEFAULT / 2) / BAUD_DEFAULT);
  localparam logic [DIV_W-1:0] DIV_FAST =
    DIV_W'((CLK_HZ + BAUD_FAST / 2) / BAUD_FAST);
  localparam int DATA_BITS    = 8;
  localparam int STOP_BITS    = 1;
  localparam int TAP_W        = 12;
  localparam int TAP_LSB      = 0;
  localparam int TAP_MSB      = 11;
  localparam int NUM_TAPS     = 4;
  localparam int NUM_TRIG     = 2;
  localparam int LEN_W        = 16;
  localparam int CMD_BYTES    = 10;
  // "w baud 24" followed by carriage return
  localparam logic [8*CMD_BYTES-1:0] CMD_BAUD_FAST =
    80'h7720_6261_7564_2032_340D;
  localparam logic FVAL_LEVEL = 1'b0;
  localparam logic DVAL_LEVEL = 1'b1;
  localparam logic LINE_IDLE  = 1'b1;

  typedef enum logic [1:0] {
    LCVO_IDLE,
    LCVO_START,
    LCVO_DATA,
    LCVO_STOP
  } lcvo_ser_st_t;
endpackage
`default_nettype wire

// [design/lcvo_ser_rx.sv]
// serial receiver, 8 data bits, no parity, one stop bit
`default_nettype none
module lcvo_ser_rx
  import lcvo_pkg::*;
#(
  parameter int DW = DATA_BITS
)
(
  input  wire logic             sys_clk,
  input  wire logic             srst,
  input  wire logic [DIV_W-1:0] bit_div,
  input  wire logic             ser_in,
  output logic [DW-1:0]         rx_data,
  output logic                  rx_valid,
  output logic                  rx_err,
  output logic                  rx_busy
);
  lcvo_ser_st_t     st_q, st_d;
  logic [DIV_W-1:0] cnt_q, cnt_d;
  logic [3:0]       bit_q, bit_d;
  logic [DW-1:0]    sh_q, sh_d;
  logic [DW-1:0]    data_q, data_d;
  logic             vld_q, vld_d;
  logic             err_q, err_d;
  logic             s1_q, s2_q, s3_q;

  wire bit_end   = (cnt_q == DIV_W'(1));
  wire last_bit  = (bit_q == 4'(DW - 1));
  wire start_hit = s3_q && !s2_q;

  assign rx_data  = data_q;
  assign rx_valid = vld_q;
  assign rx_err   = err_q;
  assign rx_busy  = (st_q != LCVO_IDLE);

  always_comb
  begin
    st_d   = st_q;
    cnt_d  = bit_end ? bit_div : cnt_q - DIV_W'(1);
    bit_d  = bit_q;
    sh_d   = sh_q;
    data_d = data_q;
    vld_d  = 1'b0;
    err_d  = 1'b0;
    case (st_q)
      LCVO_IDLE:
      begin
        cnt_d = bit_div >> 1;
        if (start_hit)
          st_d = LCVO_START;
      end
      LCVO_START:
        if (bit_end)
        begin
          // a short low glitch is not taken as a start bit
          st_d  = s2_q ? LCVO_IDLE : LCVO_DATA;
          bit_d = 4'h0;
        end
      LCVO_DATA:
        if (bit_end)
        begin
          sh_d  = {s2_q, sh_q[DW-1:1]};
          bit_d = bit_q + 4'h1;
          if (last_bit)
            st_d = LCVO_STOP;
        end
      LCVO_STOP:
        if (bit_end)
        begin
          st_d   = LCVO_IDLE;
          data_d = s2_q ? sh_q : data_q;
          vld_d  = s2_q;
          err_d  = !s2_q;
        end
      default:
        st_d = LCVO_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    s1_q <= srst ? LINE_IDLE : ser_in;
    s2_q <= srst ? LINE_IDLE : s1_q;
    s3_q <= srst ? LINE_IDLE : s2_q;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      st_q   <= LCVO_IDLE;
      cnt_q  <= DIV_DEFAULT;
      bit_q  <= 4'h0;
      sh_q   <= '0;
      data_q <= '0;
      vld_q  <= 1'b0;
      err_q  <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      bit_q  <= bit_d;
      sh_q   <= sh_d;
      data_q <= data_d;
      vld_q  <= vld_d;
      err_q  <= err_d;
    end
  end

  a_rx_valid_pulse: assert property (
    @(posedge sys_clk) disable iff (srst)
    rx_valid |=> !rx_valid)
    else $error("rx valid longer than one cycle");
  a_rx_stop_seen: assert property (
    @(posedge sys_clk) disable iff (srst)
    rx_valid |-> ($past(s2_q) && !rx_err))
    else $error("byte without stop");
endmodule
`default_nettype wire

// [design/lcvo_ser_tx.sv]
// serial transmitter, 8 data bits, no parity, one stop bit
`default_nettype none
module lcvo_ser_tx
  import lcvo_pkg::*;
#(
  parameter int DW = DATA_BITS
)
(
  input  wire logic             sys_clk,
  input  wire logic             srst,
  input  wire logic [DIV_W-1:0] bit_div,
  input  wire logic [DW-1:0]    tx_data,
  input  wire logic             tx_valid,
  output logic                  tx_ready,
  output logic                  tx_busy,
  output logic                  ser_out
);
  lcvo_ser_st_t     st_q, st_d;
  logic [DIV_W-1:0] cnt_q, cnt_d;
  logic [3:0]       bit_q, bit_d;
  logic [DW-1:0]    sh_q, sh_d;
  logic             line_q, line_d;
  logic [15:0]      frame_cnt_q;

  wire bit_end  = (cnt_q == DIV_W'(1));
  wire last_bit = (bit_q == 4'(DW - 1));
  wire take     = tx_valid && tx_ready;

  assign tx_ready = (st_q == LCVO_IDLE);
  assign tx_busy  = !tx_ready;
  assign ser_out  = line_q;

  always_comb
  begin
    st_d   = st_q;
    cnt_d  = bit_end ? bit_div : cnt_q - DIV_W'(1);
    bit_d  = bit_q;
    sh_d   = sh_q;
    line_d = line_q;
    case (st_q)
      LCVO_IDLE:
      begin
        cnt_d = bit_div;
        if (take)
        begin
          sh_d   = tx_data;
          line_d = 1'b0;
          st_d   = LCVO_START;
        end
      end
      LCVO_START:
        if (bit_end)
        begin
          line_d = sh_q[0];
          bit_d  = 4'h0;
          st_d   = LCVO_DATA;
        end
      LCVO_DATA:
        if (bit_end)
        begin
          sh_d   = sh_q >> 1;
          bit_d  = bit_q + 4'h1;
          line_d = last_bit ? LINE_IDLE : sh_q[1];
          if (last_bit)
            st_d = LCVO_STOP;
        end
      LCVO_STOP:
        if (bit_end)
          st_d = LCVO_IDLE;
      default:
        st_d = LCVO_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      st_q   <= LCVO_IDLE;
      cnt_q  <= DIV_DEFAULT;
      bit_q  <= 4'h0;
      sh_q   <= '0;
      line_q <= LINE_IDLE;
    end
    else
    begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      bit_q  <= bit_d;
      sh_q   <= sh_d;
      line_q <= line_d;
    end
  end

  always_ff @(posedge sys_clk)
    frame_cnt_q <= (srst || tx_ready) ? 16'h0000 : frame_cnt_q + 16'h0001;

  a_tx_frame_len: assert property (
    @(posedge sys_clk) disable iff (srst)
    $rose(tx_ready) |-> frame_cnt_q ==
      16'((DW + 1 + STOP_BITS) * int'(bit_div)))
    else $error("serial frame length wrong");
  a_tx_start_low: assert property (
    @(posedge sys_clk) disable iff (srst)
    take |=> !ser_out [*2])
    else $error("start bit missing");
endmodule
`default_nettype wire

// [design/lcvo_top.sv]
// line camera video output: pixel taps, triggers and serial control channel
`default_nettype none
module lcvo_top
  import lcvo_pkg::*;
#(
  parameter int TW = TAP_W,
  parameter int LW = LEN_W
)
(
  input  wire logic            sys_clk,
  input  wire logic            srst,
  input  wire logic            pix_clk,
  input  wire logic            sync_trigger_in,
  input  wire logic            exposure_start_trigger_in,
  input  wire logic            spare_ctrl3_in,
  input  wire logic            spare_ctrl4_in,
  input  wire logic            pix_valid,
  input  wire logic [TW-1:0]   pix_tap_one,
  input  wire logic [TW-1:0]   pix_tap_two,
  input  wire logic [TW-1:0]   pix_tap_three,
  input  wire logic [TW-1:0]   pix_tap_four,
  output logic [TW-1:0]        tap_one_pixel_bus,
  output logic [TW-1:0]        tap_two_pixel_bus,
  output logic [TW-1:0]        tap_three_pixel_bus,
  output logic [TW-1:0]        tap_four_pixel_bus,
  output logic                 strobe_out,
  output logic                 line_valid_out,
  output logic                 frame_valid_out,
  output logic                 data_valid_out,
  output logic                 sync_trig_level,
  output logic                 sync_trig_rise,
  output logic                 exposure_start_rise,
  output logic [LW-1:0]        line_len,
  output logic                 line_len_valid,
  input  wire logic            ser_from_grabber,
  output logic                 ser_to_grabber,
  output logic [DATA_BITS-1:0] rx_byte,
  output logic                 rx_byte_valid,
  output logic                 rx_byte_err,
  input  wire logic [DATA_BITS-1:0] tx_byte,
  input  wire logic            tx_byte_valid,
  output logic                 tx_byte_ready,
  output logic                 baud_fast
);
  // pixel clock domain
  logic                prst_s1_q, prst_q;
  logic [NUM_TRIG-1:0] trig_pins;
  logic [NUM_TRIG-1:0] t1_q, t2_q, t3_q;
  logic [NUM_TRIG-1:0] rise_q;
  logic [TW-1:0]       pix_in [NUM_TAPS];
  logic [TW-1:0]       tap_q [NUM_TAPS];
  logic                lval_q;
  logic [LW-1:0]       len_cnt_q, len_cnt_d;
  logic [LW-1:0]       len_hold_q;
  logic                req_q;
  logic                ack_q;
  logic                ack_s1_q, ack_s2_q;

  // reset arrives from the system clock; retime it before use
  always_ff @(posedge pix_clk)
  begin
    prst_s1_q <= srst;
    prst_q    <= prst_s1_q;
  end

  wire pix_rst = prst_q;

  // spare control lines are left unread on purpose
  assign trig_pins = {exposure_start_trigger_in, sync_trigger_in};

  genvar g;
  generate
    for (g = 0; g < NUM_TRIG; g++)
    begin : g_trig
      always_ff @(posedge pix_clk)
      begin
        if (pix_rst)
        begin
          t1_q[g]   <= 1'b0;
          t2_q[g]   <= 1'b0;
          t3_q[g]   <= 1'b0;
          rise_q[g] <= 1'b0;
        end
        else
        begin
          t1_q[g]   <= trig_pins[g];
          t2_q[g]   <= t1_q[g];
          t3_q[g]   <= t2_q[g];
          rise_q[g] <= t2_q[g] && !t3_q[g];
        end
      end
    end
  endgenerate

  assign sync_trig_level     = t3_q[0];
  assign sync_trig_rise      = rise_q[0];
  assign exposure_start_rise = rise_q[1];

  assign pix_in[0] = pix_tap_one;
  assign pix_in[1] = pix_tap_two;
  assign pix_in[2] = pix_tap_three;
  assign pix_in[3] = pix_tap_four;

  generate
    for (g = 0; g < NUM_TAPS; g++)
    begin : g_tap
      // hold the last pixel between lines so the bus never toggles idly
      always_ff @(posedge pix_clk)
      begin
        if (pix_rst)
          tap_q[g] <= '0;
        else if (pix_valid)
          tap_q[g] <= pix_in[g];
      end
    end
  endgenerate

  // bit TAP_LSB of each bus is the LSB, bit TAP_MSB the MSB
  assign tap_one_pixel_bus   = tap_q[0][TAP_MSB:TAP_LSB];
  assign tap_two_pixel_bus   = tap_q[1][TAP_MSB:TAP_LSB];
  assign tap_three_pixel_bus = tap_q[2][TAP_MSB:TAP_LSB];
  assign tap_four_pixel_bus  = tap_q[3][TAP_MSB:TAP_LSB];

  always_ff @(posedge pix_clk)
    lval_q <= pix_rst ? 1'b0 : pix_valid;

  assign line_valid_out  = lval_q;
  assign frame_valid_out = FVAL_LEVEL;
  assign data_valid_out  = DVAL_LEVEL;
  // inverted so the strobe rises mid-way through each data period
  assign strobe_out      = !pix_clk;

  // line length measurement, sent to the system side by toggle handshake
  wire line_end  = lval_q && !pix_valid;
  wire hs_idle   = (ack_s2_q == req_q);
  wire line_send = line_end && hs_idle;

  assign len_cnt_d = pix_valid ? len_cnt_q + LW'(1) :
                     (line_end ? '0 : len_cnt_q);

  always_ff @(posedge pix_clk)
  begin
    if (pix_rst)
    begin
      len_cnt_q  <= '0;
      len_hold_q <= '0;
      req_q      <= 1'b0;
      ack_s1_q   <= 1'b0;
      ack_s2_q   <= 1'b0;
    end
    else
    begin
      len_cnt_q <= len_cnt_d;
      ack_s1_q  <= ack_q;
      ack_s2_q  <= ack_s1_q;
      // a line ending while the previous length is in flight is dropped
      if (line_send)
      begin
        len_hold_q <= len_cnt_q;
        req_q      <= !req_q;
      end
    end
  end

  // system clock domain
  logic                   req_s1_q, req_s2_q, req_s3_q;
  logic [LW-1:0]          line_len_q;
  logic                   line_len_vld_q;
  logic [DATA_BITS-1:0]   rx_data;
  logic                   rx_valid;
  logic                   rx_busy;
  logic                   tx_busy;
  logic [8*CMD_BYTES-1:0] hist_q;
  logic                   pend_q, pend_d;
  logic                   fast_q, fast_d;
  logic [DIV_W-1:0]       bit_div;

  wire req_new = req_s2_q ^ req_s3_q;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      req_s1_q       <= 1'b0;
      req_s2_q       <= 1'b0;
      req_s3_q       <= 1'b0;
      ack_q          <= 1'b0;
      line_len_q     <= '0;
      line_len_vld_q <= 1'b0;
    end
    else
    begin
      req_s1_q       <= req_q;
      req_s2_q       <= req_s1_q;
      req_s3_q       <= req_s2_q;
      ack_q          <= req_s2_q;
      line_len_vld_q <= req_new;
      // the held length has been stable since the toggle left
      if (req_new)
        line_len_q <= len_hold_q;
    end
  end

  assign line_len       = line_len_q;
  assign line_len_valid = line_len_vld_q;

  // the rate changes only while neither direction is busy; a character starting in that cycle times its start bit at the old rate
  wire [8*CMD_BYTES-1:0] hist_shift = {hist_q[8*CMD_BYTES-9:0], rx_data};
  wire cmd_match = rx_valid && (hist_shift == CMD_BAUD_FAST);
  wire apply_now = pend_q && !tx_busy && !rx_busy;

  assign pend_d  = cmd_match || (pend_q && !apply_now);
  assign fast_d  = fast_q || apply_now;
  assign bit_div = fast_q ? DIV_FAST : DIV_DEFAULT;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      hist_q <= '0;
      pend_q <= 1'b0;
      fast_q <= 1'b0;
    end
    else
    begin
      if (rx_valid)
        hist_q <= hist_shift;
      pend_q <= pend_d;
      fast_q <= fast_d;
    end
  end

  assign baud_fast = fast_q;

  // grabber to camera
  lcvo_ser_rx #(
    .DW       (DATA_BITS)
  ) u_rx (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .bit_div  (bit_div),
    .ser_in   (ser_from_grabber),
    .rx_data  (rx_data),
    .rx_valid (rx_valid),
    .rx_err   (rx_byte_err),
    .rx_busy  (rx_busy)
  );

  // camera to grabber; no flow control, the grabber must keep up
  lcvo_ser_tx #(
    .DW       (DATA_BITS)
  ) u_tx (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .bit_div  (bit_div),
    .tx_data  (tx_byte),
    .tx_valid (tx_byte_valid),
    .tx_ready (tx_byte_ready),
    .tx_busy  (tx_busy),
    .ser_out  (ser_to_grabber)
  );

  assign rx_byte       = rx_data;
  assign rx_byte_valid = rx_valid;

  // checks
  sequence s_trig_edge(int i);
    t2_q[i] && !t3_q[i];
  endsequence

  sequence s_cmd_then_idle;
    cmd_match ##1 (pend_q && !tx_busy && !rx_busy);
  endsequence

  a_fval_low: assert property (
    @(posedge pix_clk) !frame_valid_out)
    else $error("frame valid not low");
  a_dval_high: assert property (
    @(posedge pix_clk) data_valid_out)
    else $error("data valid not high");
  a_lval_rise: assert property (
    @(posedge pix_clk) disable iff (pix_rst)
    $rose(pix_valid) |=> line_valid_out [*1] ##0
      (tap_one_pixel_bus == $past(pix_tap_one)))
    else $error("line valid or tap late at line start");
  a_lval_fall: assert property (
    @(posedge pix_clk) disable iff (pix_rst)
    $fell(pix_valid) |=> !line_valid_out)
    else $error("line valid not dropped at line end");
  a_lval_follow: assert property (
    @(posedge pix_clk) disable iff (pix_rst)
    1'b1 |=> (line_valid_out == $past(pix_valid)))
    else $error("line valid does not follow the beats");
  a_tap_load: assert property (
    @(posedge pix_clk) disable iff (pix_rst)
    pix_valid |=> (tap_four_pixel_bus == $past(pix_tap_four)) &&
      (tap_three_pixel_bus == $past(pix_tap_three)) &&
      (tap_two_pixel_bus == $past(pix_tap_two)))
    else $error("tap did not load pixel");
  a_tap_hold: assert property (
    @(posedge pix_clk) disable iff (pix_rst)
    (!pix_valid && !lval_q) |=> $stable(tap_two_pixel_bus))
    else $error("tap moved outside a line");
  a_tap_idle: assert property (
    @(posedge pix_clk) disable iff (pix_rst)
    !pix_valid |=> $stable(tap_one_pixel_bus) && $stable(tap_four_pixel_bus))
    else $error("tap moved without a beat");
  a_sync_trig: assert property (
    @(posedge pix_clk) disable iff (pix_rst)
    s_trig_edge(0) |=> sync_trig_rise ##1 !sync_trig_rise)
    else $error("sync trigger edge lost");
  a_exp_trig: assert property (
    @(posedge pix_clk) disable iff (pix_rst)
    s_trig_edge(1) |=> exposure_start_rise ##1 !exposure_start_rise)
    else $error("exposure trigger edge lost");
  a_sync_level: assert property (
    @(posedge pix_clk) disable iff (pix_rst)
    1'b1 |=> (sync_trig_level == $past(t2_q[0])))
    else $error("sync trigger level not retimed");
  a_len_count: assert property (
    @(posedge pix_clk) disable iff (pix_rst)
    line_send |=> len_hold_q == $past(len_cnt_q))
    else $error("line length not captured");
  a_len_send: assert property (
    @(posedge pix_clk) disable iff (pix_rst)
    $changed(req_q) |-> $past(hs_idle))
    else $error("line length sent while a report is in flight");
  a_len_pulse: assert property (
    @(posedge sys_clk) disable iff (srst)
    line_len_valid |=> !line_len_valid)
    else $error("line length valid longer than one cycle");
  a_len_update: assert property (
    @(posedge sys_clk) disable iff (srst)
    $changed(line_len) |-> line_len_valid)
    else $error("line length changed without valid");
  a_baud_reset: assert property (
    @(posedge sys_clk)
    srst |=> !baud_fast && (bit_div == DIV_DEFAULT))
    else $error("serial rate not default after reset");
  a_baud_switch: assert property (
    @(posedge sys_clk) disable iff (srst)
    s_cmd_then_idle |=> baud_fast && (bit_div == DIV_FAST))
    else $error("fast rate not taken after command");
  a_baud_midchar: assert property (
    @(posedge sys_clk) disable iff (srst)
    (tx_busy || rx_busy) |=> $stable(bit_div) || $past(apply_now))
    else $error("rate changed inside a character");
  a_baud_sticky: assert property (
    @(posedge sys_clk) disable iff (srst)
    baud_fast |=> baud_fast)
    else $error("fast rate lost");
  a_baud_div: assert property (
    @(posedge sys_clk) disable iff (srst)
    baud_fast |-> (bit_div == DIV_FAST))
    else $error("fast rate flag without fast divisor");
  a_tx_idle_high: assert property (
    @(posedge sys_clk) disable iff (srst)
    tx_byte_ready |-> ser_to_grabber)
    else $error("serial output low while idle");
  a_rx_err_drop: assert property (
    @(posedge sys_clk) disable iff (srst)
    rx_byte_err |-> !rx_byte_valid)
    else $error("byte taken with a bad stop bit");
endmodule
`default_nettype wire

// [design/README_unused.sv]
// holds no logic; the block lives in the other design files
`default_nettype none
`default_nettype wire

// [tb/lcvo_grabber.sv]
// frame grabber model for the serial control channel
`default_nettype none
module lcvo_grabber
  import lcvo_pkg::*;
(
  input  wire logic  sys_clk,
  input  wire logic  ser_in,
  output logic       ser_out,
  output logic [7:0] got_byte,
  output logic       got_stop,
  output logic [7:0] got_cnt
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned div = DIV_DEFAULT;

  initial ser_out = 1'b1;

  // idle high between frames; a low stop only when a scenario asks for it
  task automatic send_byte(input logic [7:0] b, input logic stop);
    logic [9:0] frm;
    frm = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      ser_out <= frm[i];
      repeat (div) @(posedge sys_clk);
    end
    ser_out <= 1'b1;
  endtask

  // receiver samples each cell in its middle, lsb first
  initial
  begin
    got_byte = 8'h00;
    got_stop = 1'b0;
    got_cnt = 8'h00;
    forever
    begin
      @(negedge ser_in);
      repeat (div / 2) @(posedge sys_clk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (div) @(posedge sys_clk);
        got_byte[i] = ser_in;
      end
      repeat (div) @(posedge sys_clk);
      got_stop = ser_in;
      got_cnt = got_cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

// [tb/test_line_camera_video_output.sv]
// self-checking bench for the line camera video output block
`default_nettype none
module test_line_camera_video_output
  import lcvo_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, srst, pix_clk, sync_trigger_in, exposure_start_trigger_in;
  logic spare_ctrl3_in, spare_ctrl4_in, pix_valid, tx_byte_valid;
  logic [11:0] pin [4];
  logic [11:0] pout [4];
  logic strobe_out, line_valid_out, frame_valid_out, data_valid_out;
  logic sync_trig_level, sync_trig_rise, exposure_start_rise;
  logic [15:0] line_len;
  logic line_len_valid, ser_from_grabber, ser_to_grabber, baud_fast;
  logic [7:0] rx_byte, tx_byte, rx_seen, got_byte, got_cnt;
  logic rx_byte_valid, rx_byte_err, tx_byte_ready, got_stop;
  int fails, compares, cycles, rx_cnt, err_cnt, n_sync, n_exp;

  lcvo_top dut (.sys_clk(sys_clk), .srst(srst), .pix_clk(pix_clk),
    .sync_trigger_in(sync_trigger_in),
    .exposure_start_trigger_in(exposure_start_trigger_in),
    .spare_ctrl3_in(spare_ctrl3_in), .spare_ctrl4_in(spare_ctrl4_in),
    .pix_valid(pix_valid), .pix_tap_one(pin[0]), .pix_tap_two(pin[1]),
    .pix_tap_three(pin[2]), .pix_tap_four(pin[3]),
    .tap_one_pixel_bus(pout[0]), .tap_two_pixel_bus(pout[1]),
    .tap_three_pixel_bus(pout[2]), .tap_four_pixel_bus(pout[3]),
    .strobe_out(strobe_out), .line_valid_out(line_valid_out),
    .frame_valid_out(frame_valid_out), .data_valid_out(data_valid_out),
    .sync_trig_level(sync_trig_level), .sync_trig_rise(sync_trig_rise),
    .exposure_start_rise(exposure_start_rise), .line_len(line_len),
    .line_len_valid(line_len_valid), .ser_from_grabber(ser_from_grabber),
    .ser_to_grabber(ser_to_grabber), .rx_byte(rx_byte),
    .rx_byte_valid(rx_byte_valid), .rx_byte_err(rx_byte_err),
    .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid),
    .tx_byte_ready(tx_byte_ready), .baud_fast(baud_fast));

  lcvo_grabber gr (.sys_clk(sys_clk), .ser_in(ser_to_grabber),
    .ser_out(ser_from_grabber), .got_byte(got_byte), .got_stop(got_stop),
    .got_cnt(got_cnt));

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // pixel clock, phase unrelated to the system clock
  initial
  begin
    pix_clk = 1'b0;
    #7;
    forever #16 pix_clk = ~pix_clk;
  end

  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    rx_cnt <= rx_cnt + int'(rx_byte_valid === 1'b1);
    err_cnt <= err_cnt + int'(rx_byte_err === 1'b1);
    if (rx_byte_valid === 1'b1)
      rx_seen <= rx_byte;
    if (cycles == 80000)
    begin
      $display("FAIL run length expected below %0d seen %0d", 80000, cycles);
      fails = fails + 1;
      give_verdict();
    end
  end

  always @(posedge pix_clk)
  begin
    n_sync <= n_sync + int'(sync_trig_rise === 1'b1);
    n_exp <= n_exp + int'(exposure_start_rise === 1'b1);
  end

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic t_reset();
    @(negedge sys_clk);
    check("ser_to_grabber", 1, ser_to_grabber);
    check("baud_fast", 0, baud_fast);
    check("tx_byte_ready", 1, tx_byte_ready);
    check("line_valid_out", 0, line_valid_out);
  endtask

  // three back-to-back beats, then the line closes
  task automatic t_pixels();
    int n;
    for (int k = 0; k < 5; k++)
    begin
      @(posedge pix_clk);
      for (int t = 0; t < 4; t++)
        pin[t] <= 12'(12'h801 + 12'h100 * t + k);
      pix_valid <= (k < 3);
      @(negedge pix_clk);
      #1;
      check("strobe_out", 1, strobe_out);
      check("frame_valid_out", 0, frame_valid_out);
      check("data_valid_out", 1, data_valid_out);
      if (k > 0)
      begin
        check("line_valid_out", k <= 3, line_valid_out);
        for (int t = 0; t < 4; t++)
          check("tap", 12'(12'h801 + 12'h100 * t + (k > 3 ? 2 : k - 1)),
                pout[t]);
      end
    end
    for (n = 0; n < 40 && line_len_valid !== 1'b1; n++)
      @(negedge sys_clk);
    check("line_len", 16'h0003, line_len);
  endtask

  task automatic t_triggers();
    @(posedge sys_clk);
    spare_ctrl3_in <= 1'b1;
    spare_ctrl4_in <= 1'b1;
    repeat (10) @(posedge pix_clk);
    check("spare pulses", 0, 16'(n_sync + n_exp));
    @(posedge sys_clk);
    sync_trigger_in <= 1'b1;
    repeat (7) @(posedge pix_clk);
    check("sync rise", 1, 16'(n_sync));
    check("sync level", 1, sync_trig_level);
    @(posedge sys_clk);
    exposure_start_trigger_in <= 1'b1;
    repeat (7) @(posedge pix_clk);
    check("exposure rise", 1, 16'(n_exp));
    check("sync rise once", 1, 16'(n_sync));
  endtask

  task automatic t_serial_in();
    @(posedge sys_clk);
    gr.send_byte(8'hA5, 1'b1);
    repeat (20) @(posedge sys_clk);
    check("rx_byte", 8'hA5, rx_seen);
    check("rx count", 1, 16'(rx_cnt));
    gr.send_byte(8'h5A, 1'b0);
    repeat (20) @(posedge sys_clk);
    check("rx err", 1, 16'(err_cnt));
    check("rx dropped", 1, 16'(rx_cnt));
  endtask

  task automatic t_serial_out();
    int n;
    @(posedge sys_clk);
    tx_byte <= 8'h3C;
    tx_byte_valid <= 1'b1;
    do
      @(posedge sys_clk);
    while (tx_byte_ready !== 1'b1);
    tx_byte_valid <= 1'b0;
    for (n = 0; n < 25000 && got_cnt !== 8'h01; n++)
      @(negedge sys_clk);
    check("tx byte", 8'h3C, got_byte);
    check("tx stop", 1, got_stop);
    repeat (DIV_DEFAULT) @(negedge sys_clk);
    check("tx ready", 1, tx_byte_ready);
    check("baud_fast", 0, baud_fast);
  endtask

  initial
  begin
    fails = 0;
    compares = 0;
    cycles = 0;
    rx_cnt = 0;
    err_cnt = 0;
    n_sync = 0;
    n_exp = 0;
    rx_seen = 8'h00;
    srst = 1'b1;
    sync_trigger_in = 1'b0;
    exposure_start_trigger_in = 1'b0;
    spare_ctrl3_in = 1'b0;
    spare_ctrl4_in = 1'b0;
    pix_valid = 1'b0;
    pin = '{default: 12'h000};
    tx_byte = 8'h00;
    tx_byte_valid = 1'b0;
    repeat (4) @(posedge sys_clk);
    t_reset();
    @(posedge sys_clk);
    srst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    t_pixels();
    t_triggers();
    t_serial_in();
    t_serial_out();
    give_verdict();
  end
endmodule
`default_nettype wire
